//--- hdl/sdmc_top.sv
// Command decode, mode registers and burst data path of the DRAM device
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdmc_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Memory command pins
	input wire logic cke,
	input wire sdmc_pkg::sdmc_pin_t pin,
	// Memory data pins
	input wire logic [15:0] dq_in,
	output logic [15:0] dq_out,
	output logic dq_oe_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	sdmc_pkg::sdmc_cmd_t cmd;
	sdmc_pkg::sdmc_mode_t mode_q, mode_d;
	sdmc_pkg::sdmc_ext_t ext_q, ext_d;
	sdmc_pkg::sdmc_slot_t p0_q, p0_d, p1_q, p1_d, src;
	logic cke_q, cke_d;
	logic ctrl_en_q, ctrl_en_d;
	logic self_ref_q, self_ref_d;
	logic [3:0] bank_open_q, bank_open_d;
	logic [7:0] aref_cnt_q, aref_cnt_d;
	logic bact_q, bact_d;
	logic bwr_q, bwr_d;
	logic bap_q, bap_d;
	logic [1:0] bbank_q, bbank_d;
	logic [8:0] bstart_q, bstart_d;
	logic [8:0] bcnt_q, bcnt_d;
	logic [2:0] blen_q, blen_d;
	logic bbt_q, bbt_d;
	logic dqm_q, dqm_d;
	logic [15:0] dq_q, dq_d;
	logic dq_oe_n_q, dq_oe_n_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;
	logic [15:0] mem [0:sdmc_pkg::MEM_DEPTH-1];
	logic [9:0] mode_key;
	logic [1:0] bank_sel;
	logic new_rw;
	logic [2:0] new_len;
	logic [8:0] ba_start;
	logic [8:0] ba_idx;
	logic [2:0] ba_len;
	logic ba_bt;
	logic [8:0] cur_col;
	logic cur_last;
	logic cur_v;
	logic cur_wr;
	logic [1:0] cur_bank;
	logic wr_en;
	logic rd_issue;
	logic [1:0] eff_lat;
	logic [31:0] stat_word;

	assign mode_key = pin.addr[9:0];
	assign bank_sel = pin.ba;

	// Command decode, gated by previous clock enable
	always_comb begin
		cmd = sdmc_pkg::CMD_NOP;
		if (cke_q && !pin.cs_n && ctrl_en_q && !self_ref_q) begin
			case ({pin.ras_n, pin.cas_n, pin.we_n})
				sdmc_pkg::ENC_MODE_LOAD: cmd = sdmc_pkg::CMD_MODE_LOAD;
				sdmc_pkg::ENC_REFRESH: begin
					cmd = cke ? sdmc_pkg::CMD_AUTO_REF : sdmc_pkg::CMD_SELF_REF;
				end
				sdmc_pkg::ENC_ACTIVATE: cmd = sdmc_pkg::CMD_ACTIVATE;
				sdmc_pkg::ENC_READ: cmd = sdmc_pkg::CMD_READ;
				sdmc_pkg::ENC_WRITE: cmd = sdmc_pkg::CMD_WRITE;
				sdmc_pkg::ENC_STOP: cmd = sdmc_pkg::CMD_STOP;
				sdmc_pkg::ENC_PRECHARGE: cmd = sdmc_pkg::CMD_PRECHARGE;
				default: cmd = sdmc_pkg::CMD_NOP;
			endcase
		end
	end

	// Word of the current cycle: a new command or the running burst
	always_comb begin
		new_rw = (cmd == sdmc_pkg::CMD_READ) || (cmd == sdmc_pkg::CMD_WRITE);
		if ((cmd == sdmc_pkg::CMD_WRITE) && mode_q.wbl) begin
			new_len = sdmc_pkg::BL_1;
		end else begin
			new_len = mode_q.bl;
		end
		ba_start = new_rw ? pin.addr[8:0] : bstart_q;
		ba_idx = new_rw ? 9'h000 : bcnt_q;
		ba_len = new_rw ? new_len : blen_q;
		ba_bt = new_rw ? mode_q.bt : bbt_q;
		cur_v = new_rw || (bact_q && cke_q && (cmd != sdmc_pkg::CMD_STOP));
		cur_wr = new_rw ? (cmd == sdmc_pkg::CMD_WRITE) : bwr_q;
		cur_bank = new_rw ? pin.ba : bbank_q;
		wr_en = cur_v && cur_wr && !pin.dqm;
		rd_issue = cur_v && !cur_wr;
	end

	sdmc_burst_addr u_addr (
		.start_col(ba_start),
		.word_idx(ba_idx),
		.len_code(ba_len),
		.order_bit(ba_bt),
		.col(cur_col),
		.last(cur_last)
	);

	// Effective read latency; reserved codes fall back to three
	always_comb begin
		case (mode_q.cl)
			sdmc_pkg::CL_1: eff_lat = 2'h1;
			sdmc_pkg::CL_2: eff_lat = 2'h2;
			default: eff_lat = 2'h3;
		endcase
	end

	// Core next state
	always_comb begin
		mode_d = mode_q;
		ext_d = ext_q;
		cke_d = cke;
		self_ref_d = self_ref_q;
		bank_open_d = bank_open_q;
		aref_cnt_d = aref_cnt_q;
		bact_d = bact_q;
		bwr_d = bwr_q;
		bap_d = bap_q;
		bbank_d = bbank_q;
		bstart_d = bstart_q;
		bcnt_d = bcnt_q;
		blen_d = blen_q;
		bbt_d = bbt_q;
		dqm_d = pin.dqm;
		if (self_ref_q && cke) begin
			self_ref_d = 1'b0;
		end
		// Burst advance; a low clock enable suspends it
		if (bact_q && cke_q) begin
			bcnt_d = 9'(bcnt_q + 9'h001);
			if (cur_last) begin
				bact_d = 1'b0;
				if (bap_q) begin
					bank_open_d[bbank_q] = 1'b0;
				end
			end
		end
		case (cmd)
			sdmc_pkg::CMD_MODE_LOAD: begin
				if (pin.ba == sdmc_pkg::BA_NORMAL) begin
					if (pin.addr[8:7] == sdmc_pkg::TM_NORMAL) begin
						mode_d = sdmc_pkg::sdmc_mode_t'(mode_key);
					end
				end else if (pin.ba == sdmc_pkg::BA_EXT) begin
					if (pin.addr[6:5] <= sdmc_pkg::DS_HALF) begin
						ext_d.ds = pin.addr[6:5];
					end
					if (pin.addr[2:0] <= sdmc_pkg::PARTIAL_ARRAY_REFRESH_QUARTER) begin
						ext_d.partial_array_refresh = pin.addr[2:0];
					end
					// Bits 4..3 carry no state
				end
			end
			sdmc_pkg::CMD_AUTO_REF: begin
				aref_cnt_d = 8'(aref_cnt_q + 8'h01);
			end
			sdmc_pkg::CMD_SELF_REF: begin
				self_ref_d = 1'b1;
				bact_d = 1'b0;
			end
			sdmc_pkg::CMD_ACTIVATE: begin
				bank_open_d[pin.ba] = 1'b1;
			end
			sdmc_pkg::CMD_PRECHARGE: begin
				if (pin.addr[sdmc_pkg::AP_BIT]) begin
					bank_open_d = 4'h0;
				end else begin
					bank_open_d[pin.ba] = 1'b0;
				end
				if (pin.addr[sdmc_pkg::AP_BIT] || (pin.ba == bbank_q)) begin
					bact_d = 1'b0;
				end
			end
			sdmc_pkg::CMD_STOP: begin
				bact_d = 1'b0;
			end
			sdmc_pkg::CMD_READ, sdmc_pkg::CMD_WRITE: begin
				bwr_d = (cmd == sdmc_pkg::CMD_WRITE);
				bap_d = pin.addr[sdmc_pkg::AP_BIT];
				bbank_d = pin.ba;
				bstart_d = pin.addr[8:0];
				blen_d = new_len;
				bbt_d = mode_q.bt;
				bcnt_d = 9'h001;
				bact_d = !cur_last;
				if (cur_last && pin.addr[sdmc_pkg::AP_BIT]) begin
					bank_open_d[pin.ba] = 1'b0;
				end
			end
			default: begin
			end
		endcase
	end

	// Read pipeline and output data
	always_comb begin
		p0_d = '{v: rd_issue, bank: cur_bank, col: cur_col};
		p1_d = p0_q;
		case (eff_lat)
			2'h1: src = p0_d;
			2'h2: src = p0_q;
			default: src = p1_q;
		endcase
		dq_d = dq_q;
		if (src.v) begin
			dq_d = mem[{src.bank, src.col}];
		end
		dq_oe_n_d = !(src.v && !dqm_q);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= sdmc_pkg::sdmc_mode_t'(sdmc_pkg::MODE_RST);
			ext_q <= sdmc_pkg::sdmc_ext_t'(sdmc_pkg::EXT_RST);
			cke_q <= 1'b0;
			self_ref_q <= 1'b0;
			bank_open_q <= 4'h0;
			aref_cnt_q <= 8'h00;
			bact_q <= 1'b0;
			bwr_q <= 1'b0;
			bap_q <= 1'b0;
			bbank_q <= 2'h0;
			bstart_q <= 9'h000;
			bcnt_q <= 9'h000;
			blen_q <= sdmc_pkg::BL_1;
			bbt_q <= sdmc_pkg::BT_SEQ;
			dqm_q <= 1'b0;
			p0_q <= '0;
			p1_q <= '0;
			dq_q <= 16'h0000;
			dq_oe_n_q <= 1'b1;
		end else if (clk_en) begin
			mode_q <= mode_d;
			ext_q <= ext_d;
			cke_q <= cke_d;
			self_ref_q <= self_ref_d;
			bank_open_q <= bank_open_d;
			aref_cnt_q <= aref_cnt_d;
			bact_q <= bact_d;
			bwr_q <= bwr_d;
			bap_q <= bap_d;
			bbank_q <= bbank_d;
			bstart_q <= bstart_d;
			bcnt_q <= bcnt_d;
			blen_q <= blen_d;
			bbt_q <= bbt_d;
			dqm_q <= dqm_d;
			p0_q <= p0_d;
			p1_q <= p1_d;
			dq_q <= dq_d;
			dq_oe_n_q <= dq_oe_n_d;
		end
	end

	// Storage array, written by unmasked burst words
	always_ff @(posedge clk) begin
		if (clk_en && wr_en) begin
			mem[{cur_bank, cur_col}] <= dq_in;
		end
	end

	assign dq_out = dq_q;
	assign dq_oe_n = dq_oe_n_q;

	// Status word
	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[sdmc_pkg::ST_BANK_LSB +: 4] = bank_open_q;
		stat_word[sdmc_pkg::ST_BURST_BIT] = bact_q;
		stat_word[sdmc_pkg::ST_WRITE_BIT] = bwr_q;
		stat_word[sdmc_pkg::ST_SREF_BIT] = self_ref_q;
		stat_word[sdmc_pkg::ST_AREF_LSB +: 8] = aref_cnt_q;
	end

	// APB slave: read data captured in setup, one-cycle access
	always_comb begin
		ctrl_en_d = ctrl_en_q;
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (psel && !penable) begin
			prdata_d = 32'h0000_0000;
			pslverr_d = 1'b0;
			if (paddr == sdmc_pkg::REG_MODE_OFS) begin
				prdata_d = {22'h000000, mode_q};
			end else if (paddr == sdmc_pkg::REG_EXT_OFS) begin
				prdata_d = {27'h0000000, ext_q};
			end else if (paddr == sdmc_pkg::REG_CTRL_OFS) begin
				prdata_d = {31'h00000000, ctrl_en_q};
			end else if (paddr == sdmc_pkg::REG_STAT_OFS) begin
				prdata_d = stat_word;
			end else begin
				pslverr_d = 1'b1;
			end
		end
		if (psel && penable && pwrite && (paddr == sdmc_pkg::REG_CTRL_OFS)) begin
			ctrl_en_d = pwdata[sdmc_pkg::CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_en_q <= sdmc_pkg::CTRL_EN_RST;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (clk_en) begin
			ctrl_en_q <= ctrl_en_d;
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = psel && penable;
	assign pslverr = pslverr_q && psel && penable;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !clk_en);

	property p_wr_mask;
		(cmd == sdmc_pkg::CMD_WRITE) |-> (wr_en == !pin.dqm);
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("write mask not same cycle");

	property p_rd_hiz;
		pin.dqm |-> ##2 dq_oe_n;
	endproperty
	a_rd_hiz: assert property (p_rd_hiz) else $error("read mask not hi-z at 2");

	property p_rd_lat2;
		(cmd == sdmc_pkg::CMD_READ && eff_lat == 2'h2 && !pin.dqm) |-> ##2 !dq_oe_n;
	endproperty
	a_rd_lat2: assert property (p_rd_lat2) else $error("latency 2 data late");

	property p_mode_load;
		(cmd == sdmc_pkg::CMD_MODE_LOAD && pin.ba == sdmc_pkg::BA_NORMAL
			&& pin.addr[8:7] == sdmc_pkg::TM_NORMAL)
			|=> (mode_q == sdmc_pkg::sdmc_mode_t'($past(mode_key)));
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode load lost");

	property p_bank_rsv;
		(cmd == sdmc_pkg::CMD_MODE_LOAD && pin.ba[0]) |=> $stable(mode_q) && $stable(ext_q);
	endproperty
	a_bank_rsv: assert property (p_bank_rsv) else $error("reserved target changed");

	property p_ext_ds;
		(cmd == sdmc_pkg::CMD_MODE_LOAD && pin.ba == sdmc_pkg::BA_EXT
			&& pin.addr[6:5] == sdmc_pkg::DS_HALF) |=> (ext_q.ds == sdmc_pkg::DS_HALF);
	endproperty
	a_ext_ds: assert property (p_ext_ds) else $error("drive strength not set");

	property p_stop;
		(cmd == sdmc_pkg::CMD_STOP) |-> !wr_en ##1 !bact_q;
	endproperty
	a_stop: assert property (p_stop) else $error("burst not stopped");

	property p_single_wr;
		(cmd == sdmc_pkg::CMD_WRITE && mode_q.wbl) |=> !bact_q;
	endproperty
	a_single_wr: assert property (p_single_wr) else $error("write burst too long");

	property p_act;
		(cmd == sdmc_pkg::CMD_ACTIVATE) |=> bank_open_q[$past(bank_sel)];
	endproperty
	a_act: assert property (p_act) else $error("bank not opened");

	property p_pre_all;
		(cmd == sdmc_pkg::CMD_PRECHARGE && pin.addr[sdmc_pkg::AP_BIT])
			|=> (bank_open_q == 4'h0);
	endproperty
	a_pre_all: assert property (p_pre_all) else $error("banks left open");

	property p_seq4;
		(bact_q && cke_q && !new_rw && blen_q == sdmc_pkg::BL_4 && bbt_q == sdmc_pkg::BT_SEQ)
			|-> (cur_col[1:0] == 2'(bstart_q[1:0] + bcnt_q[1:0]));
	endproperty
	a_seq4: assert property (p_seq4) else $error("sequential order wrong");

	property p_sref;
		(cmd == sdmc_pkg::CMD_SELF_REF) |=> self_ref_q && (cmd == sdmc_pkg::CMD_NOP);
	endproperty
	a_sref: assert property (p_sref) else $error("self refresh not entered");

	c_read_burst: cover property ((cmd == sdmc_pkg::CMD_READ) ##1 bact_q [*3]);
	c_write_mask: cover property ((cmd == sdmc_pkg::CMD_WRITE) ##1 (bact_q && pin.dqm));
	c_stop: cover property (bact_q && cmd == sdmc_pkg::CMD_STOP);
	c_sref_exit: cover property (self_ref_q ##1 !self_ref_q);
endmodule : sdmc_top
`default_nettype wire

//--- inc/sdmc_pkg.sv
// Constants and types of the mobile DRAM command decode and mode block
`default_nettype none
package sdmc_pkg;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned COL_W = 9;
	localparam int unsigned DQ_W = 16;
	localparam int unsigned MEM_DEPTH = 2048;
	localparam int unsigned AP_BIT = 10;
	// Pin encodings of ras_n, cas_n, we_n
	localparam logic [2:0] ENC_MODE_LOAD = 3'h0;
	localparam logic [2:0] ENC_REFRESH = 3'h1;
	localparam logic [2:0] ENC_PRECHARGE = 3'h2;
	localparam logic [2:0] ENC_ACTIVATE = 3'h3;
	localparam logic [2:0] ENC_WRITE = 3'h4;
	localparam logic [2:0] ENC_READ = 3'h5;
	localparam logic [2:0] ENC_STOP = 3'h6;
	// Mode load targets
	localparam logic [1:0] BA_NORMAL = 2'h0;
	localparam logic [1:0] BA_EXT = 2'h2;
	localparam logic [1:0] TM_NORMAL = 2'h0;
	// Burst length codes and masks
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_FULL = 3'h7;
	localparam logic [8:0] MASK_1 = 9'h000;
	localparam logic [8:0] MASK_2 = 9'h001;
	localparam logic [8:0] MASK_4 = 9'h003;
	localparam logic [8:0] MASK_8 = 9'h007;
	localparam logic [8:0] MASK_FULL = 9'h1FF;
	localparam logic BT_SEQ = 1'b0;
	// Read latency codes
	localparam logic [2:0] CL_1 = 3'h1;
	localparam logic [2:0] CL_2 = 3'h2;
	localparam logic [2:0] CL_3 = 3'h3;
	// Extended register codes
	localparam logic [1:0] DS_HALF = 2'h1;
	localparam logic [2:0] PARTIAL_ARRAY_REFRESH_QUARTER = 3'h2;
	// Reset values
	localparam logic [9:0] MODE_RST = 10'h022;
	localparam logic [4:0] EXT_RST = 5'h00;
	localparam logic CTRL_EN_RST = 1'b1;
	// APB register map
	localparam logic [7:0] REG_MODE_OFS = 8'h00;
	localparam logic [7:0] REG_EXT_OFS = 8'h04;
	localparam logic [7:0] REG_CTRL_OFS = 8'h08;
	localparam logic [7:0] REG_STAT_OFS = 8'h0C;
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned ST_BANK_LSB = 0;
	localparam int unsigned ST_BURST_BIT = 4;
	localparam int unsigned ST_WRITE_BIT = 5;
	localparam int unsigned ST_SREF_BIT = 6;
	localparam int unsigned ST_AREF_LSB = 8;

	typedef enum logic [3:0] {
		CMD_NOP, CMD_MODE_LOAD, CMD_AUTO_REF, CMD_SELF_REF, CMD_ACTIVATE,
		CMD_READ, CMD_WRITE, CMD_STOP, CMD_PRECHARGE
	} sdmc_cmd_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [1:0] ba;
		logic [ADDR_W-1:0] addr;
		logic dqm;
	} sdmc_pin_t;

	typedef struct packed {
		logic wbl;
		logic [1:0] test_mode;
		logic [2:0] cl;
		logic bt;
		logic [2:0] bl;
	} sdmc_mode_t;

	typedef struct packed {
		logic [1:0] ds;
		logic [2:0] partial_array_refresh;
	} sdmc_ext_t;

	typedef struct packed {
		logic v;
		logic [1:0] bank;
		logic [COL_W-1:0] col;
	} sdmc_slot_t;
endpackage : sdmc_pkg
`default_nettype wire

//--- hdl/sdmc_burst_addr.sv
// Column address of one word within a burst
`timescale 1ns/1ps
`default_nettype none
module sdmc_burst_addr (
	// Burst setup
	input wire logic [8:0] start_col,
	input wire logic [8:0] word_idx,
	input wire logic [2:0] len_code,
	input wire logic order_bit,
	// Result
	output logic [8:0] col,
	output logic last
);
	logic [8:0] mask;
	logic full;
	logic [8:0] offs;

	always_comb begin
		full = 1'b0;
		case (len_code)
			sdmc_pkg::BL_2: mask = sdmc_pkg::MASK_2;
			sdmc_pkg::BL_4: mask = sdmc_pkg::MASK_4;
			sdmc_pkg::BL_8: mask = sdmc_pkg::MASK_8;
			sdmc_pkg::BL_FULL: begin
				full = (order_bit == sdmc_pkg::BT_SEQ);
				mask = full ? sdmc_pkg::MASK_FULL : sdmc_pkg::MASK_1;
			end
			default: mask = sdmc_pkg::MASK_1;
		endcase
	end

	always_comb begin
		if (order_bit == sdmc_pkg::BT_SEQ) begin
			offs = 9'(start_col + word_idx);
		end else begin
			offs = start_col ^ word_idx;
		end
		col = (start_col & ~mask) | (offs & mask);
	end

	// Sequential full page wraps until stopped
	assign last = (word_idx == mask) && !full;
endmodule : sdmc_burst_addr
`default_nettype wire

//--- test/sdmc_cm.sv
// Memory controller model driving command, mask and write data pins
`timescale 1ns/1ps
`default_nettype none
module sdmc_cm (
	// Clock
	input wire logic clk,
	// Command pins toward the device
	output logic cke,
	output sdmc_pkg::sdmc_pin_t pin,
	// Write data toward the device
	output logic [15:0] dq_in
);
	localparam logic [2:0] ENC_IDLE = 3'h7;

	initial begin
		cke = 1'h1;
		pin = {1'h0, ENC_IDLE, 2'h0, 13'h0000, 1'h0};
		dq_in = 16'h0000;
	end

	// One command cycle; undriven data lines toggle every cycle
	task drive(input logic [2:0] enc, input logic [1:0] ba,
		input logic [12:0] a, input logic m, input logic dv,
		input logic [15:0] d);
		pin <= {1'h0, enc, ba, a, m};
		dq_in <= dv ? d : ~dq_in;
		@(posedge clk);
	endtask : drive

	task nop(input int n, input logic m = 1'h0);
		repeat (n) drive(ENC_IDLE, 2'h0, 13'h0000, m, 1'h0, 16'h0000);
	endtask : nop

	task pre_all;
		drive(sdmc_pkg::ENC_PRECHARGE, 2'h0, 13'h0400, 1'h0, 1'h0,
			16'h0000);
		nop(3);
	endtask : pre_all

	// Close every bank before any mode load
	task mode_load(input logic [1:0] ba, input logic [12:0] a);
		nop(3);
		pre_all();
		drive(sdmc_pkg::ENC_MODE_LOAD, ba, a, 1'h0, 1'h0, 16'h0000);
		nop(2);
	endtask : mode_load

	task activate(input logic [1:0] ba);
		drive(sdmc_pkg::ENC_ACTIVATE, ba, 13'($urandom), 1'h0, 1'h0,
			16'h0000);
		nop(3);
	endtask : activate

	task init(input logic [12:0] mode);
		nop(20000);
		pre_all();
		repeat (2) begin
			drive(sdmc_pkg::ENC_REFRESH, 2'h0, 13'h0000, 1'h0, 1'h0,
				16'h0000);
			nop(9);
		end
		mode_load(sdmc_pkg::BA_NORMAL, mode);
		mode_load(sdmc_pkg::BA_EXT, 13'h0000);
	endtask : init

	task sref(input logic enter);
		if (enter) begin
			pre_all();
			cke <= 1'h0;
			drive(sdmc_pkg::ENC_REFRESH, 2'h0, 13'h0000, 1'h0, 1'h0,
				16'h0000);
			nop(4);
		end else begin
			cke <= 1'h1;
			nop(3);
		end
	endtask : sref

	// Deselected cycle carrying a mode load code that must be ignored
	task desel(input logic [12:0] a);
		pin <= {1'h1, sdmc_pkg::ENC_MODE_LOAD, sdmc_pkg::BA_NORMAL, a, 1'h0};
		dq_in <= ~dq_in;
		@(posedge clk);
	endtask : desel
endmodule : sdmc_cm
`default_nettype wire

//--- test/sdmc_top_test.sv
// Self-checking bench of the DRAM command decode and mode block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin fail_count++; \
	$display("BAD t=%0t got=%0h exp=%0h", $time, (g), (x)); end end
module sdmc_top_test;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, cke, dq_oe_n;
	logic clk_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] dq_in, dq_out;
	sdmc_pkg::sdmc_pin_t pin;
	logic [15:0] mem [0:511];
	logic [8:0] base;
	int fail_count = 0;
	int checked = 0;

	sdmc_top sdmc_top_i (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.cke(cke), .pin(pin), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe_n(dq_oe_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	sdmc_cm sdmc_cm_i (.clk(clk), .cke(cke), .pin(pin), .dq_in(dq_in));

	function automatic logic [8:0] exp_col(input logic [8:0] s,
		input logic [8:0] k, input logic [2:0] bl, input logic bt);
		logic [8:0] m;
		m = (bl == sdmc_pkg::BL_2) ? sdmc_pkg::MASK_2 :
			(bl == sdmc_pkg::BL_4) ? sdmc_pkg::MASK_4 :
			(bl == sdmc_pkg::BL_8) ? sdmc_pkg::MASK_8 : sdmc_pkg::MASK_1;
		return bt ? (s ^ (k & m)) : ((s & ~m) | ((s + k) & m));
	endfunction : exp_col

	task end_sim;
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic e);
		int n;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			end_sim();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] x);
		logic e;
		apb(1'h0, a, 32'h0000_0000, rd, e);
		`CHK(rd, x)
		`CHK(e, 1'h0)
	endtask : rchk

	task rd_cmd(input logic [8:0] s, input logic ap);
		sdmc_cm_i.drive(sdmc_pkg::ENC_READ, 2'h1, {2'h0, ap, 1'h0, s},
			1'h0, 1'h0, 16'h0000);
	endtask : rd_cmd

	// Idle cycle driven after the edge, data pins sampled mid-cycle
	task nop_chk(output logic [15:0] q, output logic oe);
		fork
			sdmc_cm_i.nop(1);
			begin
				@(negedge clk);
				q = dq_out;
				oe = dq_oe_n;
			end
		join
	endtask : nop_chk

	task rd_chk(input logic [8:0] s, input int lat, input logic [2:0] bl,
		input logic bt, input logic ap);
		logic [15:0] q;
		logic oe;
		rd_cmd(s, ap);
		repeat (lat - 1) sdmc_cm_i.nop(1);
		for (int k = 0; k < (1 << bl); k++) begin
			nop_chk(q, oe);
			`CHK(q, mem[exp_col(s, 9'(k), bl, bt)])
			`CHK(oe, 1'h0)
		end
		nop_chk(q, oe);
		`CHK(oe, 1'h1)
	endtask : rd_chk

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	initial begin
		#500000;
		fail_count++;
		end_sim();
	end

	initial begin : main
		logic [12:0] ma;
		logic [15:0] d;
		logic [15:0] q;
		logic e;
		logic oe;
		rst_n = 1'h0;
		clk_en = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		void'($urandom(17403));
		repeat (12) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rchk(sdmc_pkg::REG_MODE_OFS, 32'h0000_0022);
		rchk(sdmc_pkg::REG_EXT_OFS, 32'h0000_0000);
		apb(1'h0, 8'h10, 32'h0000_0000, rd, e);
		`CHK(e, 1'h1)
		sdmc_cm_i.init(13'h0020);
		rchk(sdmc_pkg::REG_STAT_OFS, 32'h0000_0200);
		sdmc_cm_i.activate(2'h1);
		rchk(sdmc_pkg::REG_STAT_OFS, 32'h0000_0202);
		base = {6'($urandom), 3'h0};
		for (int c = 0; c < 8; c++) begin
			d = 16'($urandom);
			mem[base + 9'(c)] = d;
			sdmc_cm_i.drive(sdmc_pkg::ENC_WRITE, 2'h1,
				{4'h0, base + 9'(c)}, 1'h0, 1'h1, d);
		end
		sdmc_cm_i.drive(sdmc_pkg::ENC_WRITE, 2'h1, {4'h0, base + 9'h3},
			1'h1, 1'h1, ~mem[base + 9'h3]);
		for (int l = 1; l <= 3; l++)
		for (int t = 0; t < 2; t++)
		for (int b = 0; b < 4; b++) begin
			ma = {6'h00, l[2:0], t[0], b[2:0]};
			sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, ma);
			sdmc_cm_i.activate(2'h1);
			rchk(sdmc_pkg::REG_MODE_OFS, {19'h0, ma});
			rd_chk(base | 9'($urandom_range(7)), l, b[2:0], t[0], 1'h0);
		end
		for (int b = 0; b < 4; b++) begin
			ma = {6'h00, sdmc_pkg::CL_2, sdmc_pkg::BT_SEQ,
				(b == 3) ? sdmc_pkg::BL_FULL : 3'(b + 1)};
			sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, ma);
			sdmc_cm_i.activate(2'h1);
			rd_cmd(base, 1'h0);
			sdmc_cm_i.drive(sdmc_pkg::ENC_STOP, 2'h0, 13'h0000, 1'h0, 1'h0,
				16'h0000);
			nop_chk(q, oe);
			`CHK(q, mem[base])
			`CHK(oe, 1'h0)
			nop_chk(q, oe);
			`CHK(oe, 1'h1)
		end
		sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, 13'h0022);
		sdmc_cm_i.activate(2'h1);
		rd_cmd(base, 1'h0);
		sdmc_cm_i.nop(1, 1'h1);
		nop_chk(q, oe);
		`CHK(oe, 1'h0)
		nop_chk(q, oe);
		`CHK(oe, 1'h1)
		nop_chk(q, oe);
		`CHK(q, mem[base + 9'h2])
		`CHK(oe, 1'h0)
		sdmc_cm_i.nop(2);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, 13'h0222);
		sdmc_cm_i.activate(2'h1);
		for (int k = 0; k < 4; k++) begin
			d = 16'($urandom);
			if (k == 0) mem[base + 9'h4] = d;
			sdmc_cm_i.drive((k == 0) ? sdmc_pkg::ENC_WRITE : 3'h7, 2'h1,
				{4'h0, base + 9'h4}, 1'h0, 1'h1, d);
		end
		rd_chk(base + 9'h4, 2, sdmc_pkg::BL_4, 1'h0, 1'h1);
		rchk(sdmc_pkg::REG_STAT_OFS, 32'h0000_0200);
		sdmc_cm_i.activate(2'h0);
		sdmc_cm_i.activate(2'h2);
		sdmc_cm_i.drive(sdmc_pkg::ENC_PRECHARGE, 2'h0, 13'h0000, 1'h0,
			1'h0, 16'h0000);
		sdmc_cm_i.nop(3);
		rchk(sdmc_pkg::REG_STAT_OFS, 32'h0000_0204);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_EXT, 13'h0022);
		rchk(sdmc_pkg::REG_EXT_OFS, 32'h0000_000A);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_EXT, 13'h003B);
		rchk(sdmc_pkg::REG_EXT_OFS, 32'h0000_000A);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_EXT, 13'h0041);
		rchk(sdmc_pkg::REG_EXT_OFS, 32'h0000_0009);
		sdmc_cm_i.mode_load(2'h1, 13'h0002);
		sdmc_cm_i.mode_load(2'h3, 13'h0002);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, 13'h00A1);
		rchk(sdmc_pkg::REG_MODE_OFS, 32'h0000_0222);
		rchk(sdmc_pkg::REG_EXT_OFS, 32'h0000_0009);
		// Frozen edge, deselected cycle and disabled decode drop mode loads
		clk_en <= 1'h0;
		sdmc_cm_i.drive(sdmc_pkg::ENC_MODE_LOAD, sdmc_pkg::BA_NORMAL,
			13'h0031, 1'h0, 1'h0, 16'h0000);
		clk_en <= 1'h1;
		sdmc_cm_i.nop(2);
		sdmc_cm_i.desel(13'h0031);
		sdmc_cm_i.nop(2);
		rchk(sdmc_pkg::REG_MODE_OFS, 32'h0000_0222);
		apb(1'h1, sdmc_pkg::REG_CTRL_OFS, 32'h0000_0000, rd, e);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, 13'h0031);
		rchk(sdmc_pkg::REG_CTRL_OFS, 32'h0000_0000);
		rchk(sdmc_pkg::REG_MODE_OFS, 32'h0000_0222);
		apb(1'h1, sdmc_pkg::REG_CTRL_OFS, 32'h0000_0001, rd, e);
		rchk(sdmc_pkg::REG_CTRL_OFS, 32'h0000_0001);
		sdmc_cm_i.mode_load(sdmc_pkg::BA_NORMAL, 13'h0031);
		rchk(sdmc_pkg::REG_MODE_OFS, 32'h0000_0031);
		sdmc_cm_i.sref(1'h1);
		apb(1'h0, sdmc_pkg::REG_STAT_OFS, 32'h0000_0000, rd, e);
		`CHK(rd[sdmc_pkg::ST_SREF_BIT], 1'h1)
		sdmc_cm_i.sref(1'h0);
		apb(1'h0, sdmc_pkg::REG_STAT_OFS, 32'h0000_0000, rd, e);
		`CHK(rd[sdmc_pkg::ST_SREF_BIT], 1'h0)
		end_sim();
	end
endmodule : sdmc_top_test
`default_nettype wire
